// ===== hdl/sbsp_burst_seq.sv
// Burst address sequencer producing the two low address bits of a burst.
`timescale 1ns/1ps
module sbsp_burst_seq
  import sbsp_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    step_in,
  input  wire logic                    load_in,
  input  wire logic [SBSP_BURST_W-1:0] start_in,
  input  wire logic                    interleave_in,
  output logic      [SBSP_BURST_W-1:0] burst_addr_out
);
  import sbsp_pkg::*;

  logic [SBSP_BURST_W-1:0] start;
  logic [SBSP_BURST_W-1:0] count;

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  // Load restarts the sequence; step advances one beat and wraps after four.
  // The load beat itself uses the external bits, so the count is left one
  // ahead: otherwise the first advance would repeat the loaded address.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start <= SBSP_BURST_RST;
      count <= SBSP_BURST_RST;
    end else if (load_in) begin
      start <= start_in;
      count <= 2'h1;
    end else if (step_in) begin
      count <= count + 2'h1;
    end
  end

  // Linear order adds the beat count, interleaved order flips address bits.
  always_comb begin
    if (interleave_in) begin
      burst_addr_out = start ^ count;
    end else begin
      burst_addr_out = start + count;
    end
  end
endmodule

// ===== hdl/sbsp_pkg.sv
// Package of constants and types for the synchronous burst static memory port.
package sbsp_pkg;

  // --------------------------------------------------------------------------
  // Organisation defaults
  // --------------------------------------------------------------------------
  localparam int SBSP_ADDR_W_DEF  = 17;
  localparam int SBSP_LANES_DEF   = 4;
  localparam bit SBSP_PARITY_DEF  = 1'b1;
  localparam int SBSP_BYTE_W      = 8;
  localparam int SBSP_BURST_W     = 2;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [1:0] SBSP_BURST_RST = 2'h0;

  // Access state held in the pipeline for the word in flight.
  typedef enum logic [1:0] {
    SBSP_IDLE,
    SBSP_READ,
    SBSP_WRITE
  } sbsp_op_t;

endpackage

// ===== hdl/sbsp_top.sv
// Synchronous burst static memory port with pipelined reads and writes taking their data in the same cycle as the address.
`timescale 1ns/1ps
module sbsp_top
  import sbsp_pkg::*;
#(
  parameter int ADDR_W = SBSP_ADDR_W_DEF,
  parameter int LANES  = SBSP_LANES_DEF,
  parameter bit PARITY = SBSP_PARITY_DEF
)(
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 clk_en_n_in,
  input  wire logic [ADDR_W-1:0]    sync_address_in,
  input  wire logic                 burst_advance_load_in,
  input  wire logic                 read_write_n_in,
  input  wire logic [LANES-1:0]     byte_write_en_n_in,
  input  wire logic                 chip_select_n_in,
  input  wire logic                 chip_select_second_n_in,
  input  wire logic                 chip_select_high_in,
  input  wire logic                 burst_order_in,
  input  wire logic                 output_enable_n_in,
  input  wire logic                 snooze_request_in,
  input  wire logic [LANES*9-1:0]   data_in,
  output logic      [LANES*9-1:0]   data_out,
  output logic                      data_oe_out,
  output logic                      snooze_active_out
);
  import sbsp_pkg::*;

  localparam int LW = PARITY ? 9 : SBSP_BYTE_W;
  localparam int WW = LANES * 9;
  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------------
  // Only the 18-, 32- and 36-bit organisations exist.
  if (!(LANES == 2 || LANES == 4) || (LANES == 2 && !PARITY) || ADDR_W <= SBSP_BURST_W) begin
    $error("sbsp_top: unsupported organisation");
  end

  // ----------------------------------------------------------------------------
  // Input synchronisers for asynchronous pins
  // ----------------------------------------------------------------------------
  logic [1:0] snz_sync;
  logic [1:0] oe_sync;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      snz_sync <= 2'h0;
      oe_sync  <= 2'h3;
    end else begin
      snz_sync <= {snz_sync[0], snooze_request_in};
      oe_sync  <= {oe_sync[0], output_enable_n_in};
    end
  end

  wire snoozing = snz_sync[1];
  // Snooze overrides the clock enable so the pipeline and output word hold in standby.
  wire run = !clk_en_n_in && !snoozing;

  // ----------------------------------------------------------------------------
  // Stage 1: registered inputs
  // ----------------------------------------------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic              adv_q;
  logic              rw_n_q;
  logic [LANES-1:0]  bwe_n_q;
  logic              sel_q;
  logic [WW-1:0]     din_q;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q  <= '0;
      adv_q   <= 1'b1;
      rw_n_q  <= 1'b1;
      bwe_n_q <= '1;
      sel_q   <= 1'b0;
      din_q   <= '0;
    end else if (run) begin
      addr_q  <= sync_address_in;
      adv_q   <= burst_advance_load_in;
      rw_n_q  <= read_write_n_in;
      bwe_n_q <= byte_write_en_n_in;
      sel_q   <= !chip_select_n_in && !chip_select_second_n_in && chip_select_high_in;
      din_q   <= data_in;
    end
  end

  // ----------------------------------------------------------------------------
  // Burst state: type and select latched only on loads
  // ----------------------------------------------------------------------------
  logic     burst_sel;
  sbsp_op_t burst_op;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      burst_sel <= 1'b0;
      burst_op  <= SBSP_IDLE;
    end else if (run && !adv_q) begin
      burst_sel <= sel_q;
      burst_op  <= !sel_q ? SBSP_IDLE : (rw_n_q ? SBSP_READ : SBSP_WRITE);
    end
  end

  // On a load cycle the fresh decode applies; on advance the latched one.
  wire      cur_sel = adv_q ? burst_sel : sel_q;
  sbsp_op_t cur_op;
  always_comb begin
    if (!cur_sel) begin
      cur_op = SBSP_IDLE;
    end else if (adv_q) begin
      cur_op = burst_op;
    end else begin
      cur_op = rw_n_q ? SBSP_READ : SBSP_WRITE;
    end
  end

  logic [SBSP_BURST_W-1:0] low_addr;
  sbsp_burst_seq u_seq (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .step_in        (run && adv_q),
    .load_in        (run && !adv_q),
    .start_in       (addr_q[SBSP_BURST_W-1:0]),
    .interleave_in  (burst_order_in),
    .burst_addr_out (low_addr)
  );

  // The first beat uses the external low bits; later beats the sequencer's.
  logic [ADDR_W-1:0] base_addr;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      base_addr <= '0;
    end else if (run && !adv_q) begin
      base_addr <= addr_q;
    end
  end
  wire [ADDR_W-1:0] eff_addr = adv_q ? {base_addr[ADDR_W-1:SBSP_BURST_W], low_addr}
                                     : addr_q;

  // ----------------------------------------------------------------------------
  // Storage array with per-lane write gating
  // ----------------------------------------------------------------------------
  // Each lane keeps its own array so that a single process writes it.
  // The arrays have no reset so their contents survive snooze and reset alike.
  wire [WW-1:0] rd_word;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [8:0] lane_mem [DEPTH];
    logic [8:0] lane_rd;
    always_ff @(posedge core_clk_in) begin
      if (run && cur_op == SBSP_WRITE && !bwe_n_q[g]) begin
        lane_mem[eff_addr][LW-1:0] <= din_q[g*9 +: LW];
      end
    end
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        lane_rd <= '0;
      end else if (run && cur_op == SBSP_READ) begin
        lane_rd <= lane_mem[eff_addr];
      end
    end
    assign rd_word[g*9 +: 9] = lane_rd;
  end

  // ----------------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------------
  logic rd_valid;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_valid <= 1'b0;
    end else if (run) begin
      rd_valid <= (cur_op == SBSP_READ);
    end
  end

  // Parity bits of the 32-bit organisation read as zero.
  logic [WW-1:0] lane_mask;
  always_comb begin
    lane_mask = '0;
    for (int i = 0; i < LANES; i++) begin
      lane_mask[i*9 +: LW] = '1;
    end
  end

  // The output word freezes with the rest of the pipeline, so a held clock
  // enable cannot slip a beat out early; drivers still follow the enable pin
  // while the clock enable is held, from the validity kept for the word on the pins.
  logic drv_valid;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out          <= '0;
      drv_valid         <= 1'b0;
      data_oe_out       <= 1'b0;
      snooze_active_out <= 1'b0;
    end else begin
      if (run) begin
        data_out  <= rd_word & lane_mask;
        drv_valid <= rd_valid;
      end
      data_oe_out       <= (run ? rd_valid : drv_valid) && !oe_sync[1] && !snoozing;
      snooze_active_out <= snoozing;
    end
  end

endmodule

// ===== tb/sbsp_checker.sv
// Checker tying the port's outputs to the controls that caused them.
`timescale 1ns/1ps
module sbsp_checker #(
  parameter int LANES = 4
)(
  input wire logic                 core_clk_in,
  input wire logic                 rst_in,
  input wire logic                 clk_en_n_in,
  input wire logic                 burst_advance_load_in,
  input wire logic                 read_write_n_in,
  input wire logic                 chip_select_n_in,
  input wire logic                 chip_select_second_n_in,
  input wire logic                 chip_select_high_in,
  input wire logic                 output_enable_n_in,
  input wire logic                 snooze_request_in,
  input wire logic [LANES*9-1:0]   data_out,
  input wire logic                 data_oe_out,
  input wire logic                 snooze_active_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Qualified edges; standby or a held clock enable stall the pipeline.
  wire en  = !clk_en_n_in && !snooze_request_in && !snooze_active_out;
  wire sel = !chip_select_n_in && !chip_select_second_n_in && chip_select_high_in;
  wire ld  = en && !burst_advance_load_in;
  wire go  = en && !output_enable_n_in;
  // A selected read load with the output enable settled ahead of it.
  sequence s_rd;
    !output_enable_n_in[*2] ##1 (ld && sel && read_write_n_in && go);
  endsequence
  AST_DESEL: assert property ((ld && !sel) ##1 en[*2] |=> !data_oe_out)
    else $error("deselected access drove data");
  AST_WR_BURST: assert property ((ld && sel && !read_write_n_in)
    ##1 (en && burst_advance_load_in) ##1 en[*2] |=> !data_oe_out)
    else $error("write burst beat drove data");
  AST_RD_OE: assert property (s_rd ##1 go[*2] |=> data_oe_out)
    else $error("read did not drive data");
  AST_RD_ADV: assert property (s_rd ##1 (go && burst_advance_load_in)
    ##1 go[*2] |=> data_oe_out)
    else $error("read burst beat not driven");
  AST_CKE_HOLD: assert property ((clk_en_n_in && !snooze_request_in
    && !snooze_active_out) |=> $stable(data_out) && $stable(data_oe_out))
    else $error("outputs moved with clock enable off");
  AST_OE_OFF: assert property ((output_enable_n_in && en)[*4] |=> !data_oe_out)
    else $error("data driven with output enable off");
  AST_SNZ_ON: assert property (snooze_request_in[*4] |=> snooze_active_out)
    else $error("standby not entered");
  AST_SNZ_HOLD: assert property (snooze_active_out[*3] |->
    $stable(data_out) && !data_oe_out)
    else $error("outputs active in standby");
endmodule
bind sbsp_top sbsp_checker #(.LANES(LANES)) u_chk (.core_clk_in, .rst_in, .clk_en_n_in,
  .burst_advance_load_in, .read_write_n_in, .chip_select_n_in, .chip_select_second_n_in,
  .chip_select_high_in, .output_enable_n_in, .snooze_request_in, .data_out, .data_oe_out,
  .snooze_active_out);

// ===== tb/sbsp_ctrl_bfm.sv
// Memory controller model driving the port's synchronous inputs.
`timescale 1ns/1ps
module sbsp_ctrl_bfm (
  output logic        adv_out,
  output logic        rw_n_out,
  output logic [3:0]  bwe_n_out,
  output logic [5:0]  addr_out,
  output logic [35:0] wdata_out,
  output logic [2:0]  sel_out,
  output logic        order_out
);
  logic wr_burst = 1'b0;
  // The bus idles deselected, in linear order.
  initial begin
    {adv_out, rw_n_out, bwe_n_out, addr_out} = {1'b0, 1'b1, 4'hf, 6'h00};
    wdata_out = 36'h0;
    sel_out = 3'h3;
    order_out = 1'b0;
  end
  // Enables follow the type taken at the load; idle data lines keep toggling.
  task automatic cyc(input logic adv, input logic rw, input logic [3:0] be,
                     input logic [5:0] a, input logic [35:0] d, input logic [2:0] s);
    if (!adv) wr_burst = !rw;
    adv_out = adv;
    rw_n_out = rw;
    bwe_n_out = wr_burst ? be : 4'hf;
    addr_out = a;
    sel_out = s;
    wdata_out = wr_burst ? d : ~wdata_out;
  endtask
  // Order is only changed between bursts.
  task automatic mode(input logic o);
    order_out = o;
  endtask
endmodule

// ===== tb/tb_top.sv
// Testbench running bursts through the controller model against a reference memory.
`timescale 1ns/1ps
module tb_top;
  import sbsp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cke_n = 1'b0;
  logic        oe_n = 1'b0;
  logic        snz = 1'b0;
  logic        adv, rw, ord, oe, za;
  logic [3:0]  bwe;
  logic [5:0]  ad;
  logic [2:0]  sl, sv;
  logic [35:0] wd, rd;
  logic [35:0] mem [64];
  logic [36:0] exq [$];
  sbsp_op_t    typ = SBSP_IDLE;
  logic [5:0]  base = 6'h00;
  logic [1:0]  cnt = 2'h0;
  int          error_cnt = 0;
  int          samples_checked = 0;
  // Clock of 40 ns period.
  initial forever #20 clk = ~clk;
  sbsp_ctrl_bfm ctrl (.adv_out(adv), .rw_n_out(rw), .bwe_n_out(bwe), .addr_out(ad),
                      .wdata_out(wd), .sel_out(sl), .order_out(ord));
  sbsp_top #(.ADDR_W(6), .LANES(4), .PARITY(1'b1)) DUT (.core_clk_in(clk), .rst_in(rst),
    .clk_en_n_in(cke_n), .sync_address_in(ad), .burst_advance_load_in(adv),
    .read_write_n_in(rw), .byte_write_en_n_in(bwe), .chip_select_n_in(sl[0]),
    .chip_select_second_n_in(sl[1]), .chip_select_high_in(sl[2]), .burst_order_in(ord),
    .output_enable_n_in(oe_n), .snooze_request_in(snz), .data_in(wd), .data_out(rd),
    .data_oe_out(oe), .snooze_active_out(za));
  task automatic chk(input string what, input logic [35:0] ex, input logic [35:0] got);
    samples_checked++;
    if (ex !== got) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", what, ex, got);
    end
  endtask
  // One cycle; its result shows three enabled cycles later, so a queue keeps it.
  task automatic bt(input logic a, input logic r, input logic [3:0] b,
                    input logic [5:0] ai, input logic [35:0] d, input logic [2:0] s);
    logic [5:0]  x;
    logic [36:0] e;
    @(negedge clk);
    cke_n = 1'b0;
    if (exq.size() == 3) begin
      e = exq.pop_front();
      chk("oe", {35'h0, e[36]}, {35'h0, oe});
      if (e[36]) chk("rdata", e[35:0], rd);
    end
    if (!a) begin
      base = ai;
      cnt = 2'h0;
      typ = (s != 3'h4) ? SBSP_IDLE : (r ? SBSP_READ : SBSP_WRITE);
    end else cnt++;
    x = {base[5:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (typ == SBSP_WRITE)
      for (int i = 0; i < 4; i++) if (!b[i]) mem[x][i*9+:9] = d[i*9+:9];
    exq.push_back({typ == SBSP_READ && !oe_n, mem[x]});
    ctrl.cyc(a, r, b, ai, d, s);
  endtask
  task automatic idl(input int n);
    repeat (n) bt(1'b0, 1'b1, 4'hf, 6'h00, 36'h0, 3'h3);
  endtask
  task automatic wb(input logic [5:0] a);
    for (int j = 0; j < 4; j++) bt(j != 0, j[0], 4'h0, a, 36'h5a5a5a5a5 ^ {6{a + 6'(j)}}, 3'h4);
  endtask
  task automatic rb(input logic [5:0] a, input logic [2:0] s);
    for (int j = 0; j < 4; j++) bt(j != 0, j == 0, 4'hf, a, 36'h0, j == 0 ? 3'h4 : s);
  endtask
  // A held clock enable with a write on the pins that must be ignored.
  task automatic frz(input int n);
    repeat (n) begin
      @(negedge clk);
      cke_n = 1'b1;
      ctrl.cyc(1'b0, 1'b0, 4'h0, 6'h00, 36'h0, 3'h4);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the run needs about a hundred cycles, so 2000 means a hang.
  initial begin
    #80000;
    error_cnt++;
    finish_test();
  end
  // Main sequence; inputs change only at falling edges.
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 16; k += 4) wb(6'(k));
    for (int k = 1; k < 16; k += 4) rb(6'(k), 3'h3);
    idl(2);
    ctrl.mode(1'b1);
    rb(6'h05, 3'h4);
    idl(2);
    ctrl.mode(1'b0);
    $display("test burst done");
    bt(1'b0, 1'b0, 4'ha, 6'h02, 36'hf0f0f0f0f, 3'h4);
    rb(6'h02, 3'h4);
    for (int i = 0; i < 3; i++) begin
      sv = i == 0 ? 3'h5 : i == 1 ? 3'h6 : 3'h0;
      bt(1'b0, 1'b0, 4'h0, 6'h03, 36'h0, sv);
      bt(1'b0, 1'b1, 4'hf, 6'h03, 36'h0, sv);
    end
    rb(6'h03, 3'h4);
    bt(1'b0, 1'b1, 4'hf, 6'h08, 36'h0, 3'h4);
    frz(3);
    for (int j = 0; j < 3; j++) bt(1'b1, 1'b0, 4'hf, 6'h08, 36'h0, 3'h3);
    idl(3);
    oe_n = 1'b1;
    idl(3);
    bt(1'b0, 1'b1, 4'hf, 6'h09, 36'h0, 3'h4);
    idl(3);
    oe_n = 1'b0;
    idl(3);
    $display("test control done");
    snz = 1'b1;
    repeat (4) @(negedge clk);
    chk("standby", 36'h1, {35'h0, za});
    ctrl.cyc(1'b0, 1'b0, 4'h0, 6'h00, 36'h0, 3'h4);
    repeat (4) @(negedge clk);
    ctrl.cyc(1'b0, 1'b1, 4'hf, 6'h00, 36'h0, 3'h3);
    snz = 1'b0;
    repeat (5) @(negedge clk);
    chk("standby", 36'h0, {35'h0, za});
    rb(6'h00, 3'h4);
    idl(3);
    $display("test snooze done");
    finish_test();
  end
endmodule
